/* inc/ccr_pkg.sv */
`default_nettype none
package ccr_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 2;
  localparam int STAT_W = 3;

  // Register offsets (word index on the plain register port)
  localparam logic [1:0] ADDR_VALUE   = 2'h0;
  localparam logic [1:0] ADDR_CONTROL = 2'h1;
  localparam logic [1:0] ADDR_STATUS  = 2'h2;
  localparam logic [1:0] ADDR_MASK    = 2'h3;

  localparam logic [15:0] VALUE_RESET   = 16'h0000;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [2:0]  STATUS_RESET  = 3'h0;
  localparam logic [2:0]  MASK_RESET    = 3'h0;

  // Sticky event bits of the status and mask registers
  localparam int STAT_CAPTURE = 0;
  localparam int STAT_MATCH   = 1;
  localparam int STAT_LOST    = 2;

  // Control field positions, matching the struct below
  localparam int FLD_IRQ_FLAG  = 0;
  localparam int FLD_LOST_FLAG = 1;
  localparam int FLD_DRIVE     = 2;
  localparam int FLD_IN_LEVEL  = 3;
  localparam int FLD_IRQ_EN    = 4;
  localparam int FLD_OUT_MODE  = 5;
  localparam int FLD_MODE_SEL  = 8;
  localparam int FLD_UNUSED    = 9;
  localparam int FLD_LATCHED   = 10;
  localparam int FLD_SYNC_EN   = 11;
  localparam int FLD_SOURCE    = 12;
  localparam int FLD_EDGE      = 14;

  typedef enum logic [1:0] {
    CCR_EDGE_NONE = 2'h0,
    CCR_EDGE_RISE = 2'h1,
    CCR_EDGE_FALL = 2'h2,
    CCR_EDGE_BOTH = 2'h3
  } ccr_edge_e;

  typedef enum logic [1:0] {
    CCR_SRC_A   = 2'h0,
    CCR_SRC_B   = 2'h1,
    CCR_SRC_GND = 2'h2,
    CCR_SRC_VCC = 2'h3
  } ccr_src_e;

  typedef enum logic [2:0] {
    CCR_OUT_BIT          = 3'h0,
    CCR_OUT_SET          = 3'h1,
    CCR_OUT_TOGGLE_RESET = 3'h2,
    CCR_OUT_SET_RESET    = 3'h3,
    CCR_OUT_TOGGLE       = 3'h4,
    CCR_OUT_RESET        = 3'h5,
    CCR_OUT_TOGGLE_SET   = 3'h6,
    CCR_OUT_RESET_SET    = 3'h7
  } ccr_outmode_e;

  typedef struct packed {
    ccr_edge_e    edgeSelect;
    ccr_src_e     inputSourceSelect;
    logic         inputSyncEnable;
    logic         latchedInputLevel;
    logic         unusedBit;
    logic         modeSelectBit;
    ccr_outmode_e outputModeField;
    logic         channelIrqEnable;
    logic         channelInputLevel;
    logic         driveLevel;
    logic         captureLostFlag;
    logic         channelIrqFlag;
  } ccr_ctrl_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [1:0]  addr;
    logic [15:0] wdata;
  } ccr_req_s;

endpackage
`default_nettype wire

/* rtl/ccr_channel_regs.sv */
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
module ccr_channel_regs #(
  parameter int WIDTH = 16
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire ccr_pkg::ccr_req_s busReq,
  output logic [15:0]            readData,
  input  wire logic [15:0]       timerCountValue,
  input  wire logic              inputSourceA,
  input  wire logic              inputSourceB,
  output logic                   outLevel,
  output logic                   irq
);

  generate
    if (WIDTH != ccr_pkg::DATA_W) begin : g_bad
      $error("ccr_channel_regs supports only a 16-bit channel");
    end
  endgenerate

  ccr_pkg::ccr_ctrl_s ctrl;
  ccr_pkg::ccr_ctrl_s next_ctrl;
  ccr_pkg::ccr_ctrl_s wrCtrlData;
  ccr_pkg::ccr_ctrl_s ctrlView;

  logic [15:0] chanValue;
  logic [15:0] next_value;
  logic [2:0]  status;
  logic [2:0]  next_status;
  logic [2:0]  mask;
  logic [2:0]  events;
  logic [15:0] rdMux;
  logic [1:0]  syncPins;
  logic        selLevel;
  logic        rawEdge;
  logic        rawEdgeD;
  logic        eqPrev;
  logic        pending;
  logic        next_out;

  // Register port decode
  wire wrValue   = busReq.wr && (busReq.addr == ccr_pkg::ADDR_VALUE);
  wire wrControl = busReq.wr && (busReq.addr == ccr_pkg::ADDR_CONTROL);
  wire wrStatus  = busReq.wr && (busReq.addr == ccr_pkg::ADDR_STATUS);
  wire wrMask    = busReq.wr && (busReq.addr == ccr_pkg::ADDR_MASK);
  wire rdValue   = busReq.rd && (busReq.addr == ccr_pkg::ADDR_VALUE);

  assign wrCtrlData = ccr_pkg::ccr_ctrl_s'(busReq.wdata);

  // Pins cross into the ref_clk domain before anything looks at them
  ccr_sync #(
    .WIDTH (2)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .asyncIn ({inputSourceB, inputSourceA}),
    .syncOut (syncPins)
  );

  always_comb begin
    case (ctrl.inputSourceSelect)
      ccr_pkg::CCR_SRC_A:   selLevel = syncPins[0];
      ccr_pkg::CCR_SRC_B:   selLevel = syncPins[1];
      ccr_pkg::CCR_SRC_GND: selLevel = 1'b0;
      default:              selLevel = 1'b1;
    endcase
  end

  // Switching the source can itself look like an edge; stop first
  ccr_edge_detect u_edge (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .level      (selLevel),
    .edgeSelect (ctrl.edgeSelect),
    .edgeHit    (rawEdge)
  );

  // Synchronous capture waits one extra stage to align to the clock
  wire capturePulse = ctrl.modeSelectBit
                    && (ctrl.inputSyncEnable ? rawEdgeD : rawEdge);

  // Match fires once on entering equality, not every cycle it holds
  wire eqNow      = (timerCountValue == chanValue);
  wire matchPulse = !ctrl.modeSelectBit && eqNow && !eqPrev;

  assign events = {capturePulse && pending, matchPulse, capturePulse};

  // Capture beats a software write of the same cycle
  assign next_value = capturePulse ? timerCountValue :
                      wrValue      ? busReq.wdata : chanValue;

  assign next_status = (status & ~(wrStatus ? busReq.wdata[2:0] : 3'h0))
                     | events;

  // Control register: hardware sets win over software writes
  assign next_ctrl.edgeSelect        = wrControl ? wrCtrlData.edgeSelect
                                                 : ctrl.edgeSelect;
  assign next_ctrl.inputSourceSelect = wrControl ? wrCtrlData.inputSourceSelect
                                                 : ctrl.inputSourceSelect;
  assign next_ctrl.inputSyncEnable   = wrControl ? wrCtrlData.inputSyncEnable
                                                 : ctrl.inputSyncEnable;
  assign next_ctrl.latchedInputLevel = matchPulse ? selLevel
                                                  : ctrl.latchedInputLevel;
  assign next_ctrl.unusedBit         = 1'b0;
  assign next_ctrl.modeSelectBit     = wrControl ? wrCtrlData.modeSelectBit
                                                 : ctrl.modeSelectBit;
  assign next_ctrl.outputModeField   = wrControl ? wrCtrlData.outputModeField
                                                 : ctrl.outputModeField;
  assign next_ctrl.channelIrqEnable  = wrControl ? wrCtrlData.channelIrqEnable
                                                 : ctrl.channelIrqEnable;
  assign next_ctrl.channelInputLevel = 1'b0;
  assign next_ctrl.driveLevel        = wrControl ? wrCtrlData.driveLevel
                                                 : ctrl.driveLevel;
  assign next_ctrl.captureLostFlag   = (capturePulse && pending) ? 1'b1
                                     : wrControl ? wrCtrlData.captureLostFlag
                                     : ctrl.captureLostFlag;
  assign next_ctrl.channelIrqFlag    = (capturePulse || matchPulse) ? 1'b1
                                     : wrControl ? wrCtrlData.channelIrqFlag
                                     : ctrl.channelIrqFlag;

  // Only a few output modes are kept; the rest hold their level
  always_comb begin
    case (ctrl.outputModeField)
      ccr_pkg::CCR_OUT_BIT:    next_out = ctrl.driveLevel;
      ccr_pkg::CCR_OUT_SET:    next_out = matchPulse | outLevel;
      ccr_pkg::CCR_OUT_TOGGLE: next_out = matchPulse ^ outLevel;
      ccr_pkg::CCR_OUT_RESET:  next_out = !matchPulse & outLevel;
      default:                 next_out = outLevel;
    endcase
  end

  // Live input level is shown, not stored
  always_comb begin
    ctrlView                   = ctrl;
    ctrlView.channelInputLevel = selLevel;
    ctrlView.unusedBit         = 1'b0;
  end

  always_comb begin
    case (busReq.addr)
      ccr_pkg::ADDR_VALUE:   rdMux = chanValue;
      ccr_pkg::ADDR_CONTROL: rdMux = 16'(ctrlView);
      ccr_pkg::ADDR_STATUS:  rdMux = {13'h0000, status};
      ccr_pkg::ADDR_MASK:    rdMux = {13'h0000, mask};
      default:               rdMux = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      chanValue <= ccr_pkg::VALUE_RESET;
      ctrl      <= ccr_pkg::ccr_ctrl_s'(ccr_pkg::CONTROL_RESET);
      status    <= ccr_pkg::STATUS_RESET;
      mask      <= ccr_pkg::MASK_RESET;
    end else begin
      chanValue <= next_value;
      ctrl      <= next_ctrl;
      status    <= next_status;
      mask      <= wrMask ? busReq.wdata[2:0] : mask;
    end
  end

  // A read of the value register services the held capture
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pending  <= 1'b0;
      rawEdgeD <= 1'b0;
      eqPrev   <= 1'b0;
    end else begin
      pending  <= capturePulse ? 1'b1 : (rdValue ? 1'b0 : pending);
      rawEdgeD <= rawEdge;
      eqPrev   <= eqNow;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      readData <= 16'h0000;
      outLevel <= 1'b0;
      irq      <= 1'b0;
    end else begin
      readData <= busReq.rd ? rdMux : 16'h0000;
      outLevel <= next_out;
      irq      <= (|(status & mask))
               || (ctrl.channelIrqFlag && ctrl.channelIrqEnable);
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_match_sets_flags: assert property (
    (!ctrl.modeSelectBit && (timerCountValue == chanValue) && !eqPrev)
    |=> (status[ccr_pkg::STAT_MATCH] && ctrl.channelIrqFlag)
  ) else $error("Match did not set its flags");

  a_capture_copies_count: assert property (
    capturePulse |=> (chanValue == $past(timerCountValue))
  ) else $error("Captured value differs from count");

  a_async_capture_now: assert property (
    (ctrl.modeSelectBit && !ctrl.inputSyncEnable && rawEdge)
    |=> (chanValue == $past(timerCountValue))
  ) else $error("Async capture not taken at once");

  a_sync_capture_late: assert property (
    (ctrl.modeSelectBit && ctrl.inputSyncEnable && rawEdge && !wrControl)
    |=> capturePulse
  ) else $error("Sync capture not one cycle late");

  a_latch_on_match: assert property (
    matchPulse |=> (ctrl.latchedInputLevel == $past(selLevel))
  ) else $error("Latched input level wrong after match");

  a_out_follows_bit: assert property (
    (ctrl.outputModeField == ccr_pkg::CCR_OUT_BIT)
    |=> (outLevel == $past(ctrl.driveLevel))
  ) else $error("Output does not follow drive level");

  a_lost_on_overrun: assert property (
    (capturePulse && pending) |=> (ctrl.captureLostFlag && pending)
  ) else $error("Overrun did not set capture lost flag");

  a_lost_stays_set: assert property (
    (ctrl.captureLostFlag && !(wrControl && !wrCtrlData.captureLostFlag))
    |=> ctrl.captureLostFlag
  ) else $error("Capture lost flag cleared by itself");

  a_compare_no_capture: assert property (
    (!ctrl.modeSelectBit && !wrValue)
    |=> (chanValue == $past(chanValue))
  ) else $error("Capture taken in compare mode");

  a_irq_level: assert property (
    (|(status & mask)) |=> irq
  ) else $error("Interrupt output missing");

  a_write_value: assert property (
    (wrValue && !capturePulse) |=> (chanValue == $past(busReq.wdata))
  ) else $error("Value write not stored");

  a_match_once: assert property (
    (!ctrl.modeSelectBit && eqNow && eqPrev && !ctrl.channelIrqFlag
     && !wrControl) |=> !ctrl.channelIrqFlag
  ) else $error("Held equality matched again");

  a_capture_status: assert property (
    capturePulse |=> (status[ccr_pkg::STAT_CAPTURE] && ctrl.channelIrqFlag)
  ) else $error("Capture did not set its flags");

  a_latched_holds: assert property (
    !matchPulse
    |=> (ctrl.latchedInputLevel == $past(ctrl.latchedInputLevel))
  ) else $error("Latched input level changed without match");

  a_lost_sets_status: assert property (
    (capturePulse && pending) |=> status[ccr_pkg::STAT_LOST]
  ) else $error("Overrun did not set its status bit");

  a_lost_write_clear: assert property (
    (wrControl && !wrCtrlData.captureLostFlag && !(capturePulse && pending))
    |=> !ctrl.captureLostFlag
  ) else $error("Capture lost flag not cleared by write");

  a_status_set_wins: assert property (
    (|events) |=> ((status & $past(events)) == $past(events))
  ) else $error("Status clear beat a same-cycle event");

  a_read_idle_zero: assert property (
    !busReq.rd |=> (readData == 16'h0000)
  ) else $error("Read data not zero outside a read");

  a_read_value: assert property (
    (busReq.rd && busReq.addr == ccr_pkg::ADDR_VALUE)
    |=> (readData == $past(chanValue))
  ) else $error("Value read returned wrong data");

  a_irq_flag_enable: assert property (
    (ctrl.channelIrqFlag && ctrl.channelIrqEnable) |=> irq
  ) else $error("Enabled flag did not raise interrupt");

  a_irq_quiet: assert property (
    !((|(status & mask)) || (ctrl.channelIrqFlag && ctrl.channelIrqEnable))
    |=> !irq
  ) else $error("Interrupt raised with nothing pending");

  a_out_toggle_match: assert property (
    (ctrl.outputModeField == ccr_pkg::CCR_OUT_TOGGLE && matchPulse)
    |=> (outLevel != $past(outLevel))
  ) else $error("Toggle mode did not toggle on match");

  c_capture: cover property (capturePulse ##1 rdValue);
  c_match:   cover property (matchPulse ##1 irq);
  c_overrun: cover property (capturePulse ##[1:20] capturePulse && pending);
  c_toggle:  cover property (ctrl.outputModeField == ccr_pkg::CCR_OUT_TOGGLE
                             && matchPulse);

endmodule
`default_nettype wire

/* rtl/ccr_edge_detect.sv */
`timescale 1ns/1ns
`default_nettype none
module ccr_edge_detect (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic                level,
  input  wire ccr_pkg::ccr_edge_e  edgeSelect,
  output logic                     edgeHit
);

  logic prevLevel;
  wire  rose = level & ~prevLevel;
  wire  fell = ~level & prevLevel;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prevLevel <= 1'b0;
    end else begin
      prevLevel <= level;
    end
  end

  always_comb begin
    case (edgeSelect)
      ccr_pkg::CCR_EDGE_RISE: edgeHit = rose;
      ccr_pkg::CCR_EDGE_FALL: edgeHit = fell;
      ccr_pkg::CCR_EDGE_BOTH: edgeHit = rose | fell;
      default:                edgeHit = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

/* rtl/ccr_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module ccr_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;

  generate
    if (WIDTH < 1) begin : g_bad
      $error("ccr_sync needs WIDTH of at least one");
    end
  endgenerate

  // Stage one feeds stage two only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stage1  <= '0;
      syncOut <= '0;
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule
`default_nettype wire

/* test/ccr_channel_regs_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module ccr_channel_regs_bench;
  logic              ref_clk;
  logic              rst_n;
  ccr_pkg::ccr_req_s busReq;
  logic [15:0]       readData;
  logic [15:0]       timerCountValue;
  logic              inputSourceA;
  logic              inputSourceB;
  logic              outLevel;
  logic              irq;
  logic              run;
  logic              load;
  logic [15:0]       loadValue;
  logic              levelA;
  logic              levelB;
  logic              pend;
  int                failures;
  int                n_checks;
  logic [15:0]       expQ[$];
  string             nameQ[$];
  logic [15:0]       prev;
  logic [15:0]       cnt;
  logic [15:0]       ctl;

  ccr_channel_regs DUT (.ref_clk(ref_clk), .rst_n(rst_n), .busReq(busReq),
    .readData(readData), .timerCountValue(timerCountValue),
    .inputSourceA(inputSourceA), .inputSourceB(inputSourceB),
    .outLevel(outLevel), .irq(irq));
  ccr_far_side FAR (.ref_clk(ref_clk), .rst_n(rst_n), .run(run),
    .load(load), .loadValue(loadValue), .levelA(levelA), .levelB(levelB),
    .timerCountValue(timerCountValue), .inputSourceA(inputSourceA),
    .inputSourceB(inputSourceB));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Read data stands only one cycle, so the watcher samples it right then
  always @(posedge ref_clk) begin
    if (pend) begin
      chk(nameQ.pop_front(), expQ.pop_front(), readData);
    end
    pend <= busReq.rd;
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    busReq.wr    <= 1'b1;
    busReq.addr  <= a;
    busReq.wdata <= d;
    ticks(1);
    busReq.wr <= 1'b0;
    ticks(1);
  endtask

  task automatic rd(input string what, input logic [1:0] a,
                    input logic [15:0] e);
    busReq.rd   <= 1'b1;
    busReq.addr <= a;
    expQ.push_back(e);
    nameQ.push_back(what);
    ticks(1);
    busReq.rd <= 1'b0;
    ticks(1);
  endtask

  task automatic setCount(input logic [15:0] v);
    load      <= 1'b1;
    loadValue <= v;
    ticks(1);
    load <= 1'b0;
  endtask

  task automatic results;
    $display("Checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    ticks(3000);
    failures++;
    $display("BAD watchdog expired");
    results();
  end

  initial begin
    busReq = '0;
    rst_n = 1'b0;
    {run, load, levelA, levelB} = 4'h0;
    loadValue = 16'h0000;
    failures = 0;
    n_checks = 0;
    void'($urandom(32'h5853));
    ticks(4);
    rst_n <= 1'b1;
    ticks(1);
    for (int i = 0; i < 4; i++) rd("reset", 2'(i), 16'h0000);
    chk("out reset", 16'h0000, {15'h0, outLevel});
    chk("irq reset", 16'h0000, {15'h0, irq});
    $display("reset test done");

    cnt = 16'($urandom()) | 16'h8000;
    wr(ccr_pkg::ADDR_VALUE, cnt);
    rd("value rw", ccr_pkg::ADDR_VALUE, cnt);
    wr(ccr_pkg::ADDR_CONTROL, 16'h0E04);
    rd("control ro", ccr_pkg::ADDR_CONTROL, 16'h0804);
    chk("out high", 16'h0001, {15'h0, outLevel});
    wr(ccr_pkg::ADDR_CONTROL, 16'h0000);
    ticks(1);
    chk("out low", 16'h0000, {15'h0, outLevel});
    $display("register test done");

    cnt = 16'h1000 + 16'($urandom() & 32'hFF);
    setCount(cnt);
    levelA <= 1'b1;
    wr(ccr_pkg::ADDR_VALUE, cnt + 16'h0008);
    wr(ccr_pkg::ADDR_CONTROL, 16'h0090);
    run <= 1'b1;
    ticks(20);
    run <= 1'b0;
    ticks(2);
    chk("irq match", 16'h0001, {15'h0, irq});
    chk("out toggle", 16'h0001, {15'h0, outLevel});
    rd("match ctl", ccr_pkg::ADDR_CONTROL, 16'h0499);
    rd("match stat", ccr_pkg::ADDR_STATUS, 16'h0002);
    wr(ccr_pkg::ADDR_CONTROL, 16'h0000);
    rd("latched ro", ccr_pkg::ADDR_CONTROL, 16'h0408);
    chk("irq flag off", 16'h0000, {15'h0, irq});
    wr(ccr_pkg::ADDR_MASK, 16'h0002);
    ticks(1);
    chk("irq masked on", 16'h0001, {15'h0, irq});
    wr(ccr_pkg::ADDR_STATUS, 16'h0002);
    ticks(1);
    chk("irq cleared", 16'h0000, {15'h0, irq});
    rd("stat clear", ccr_pkg::ADDR_STATUS, 16'h0000);
    $display("compare test done");

    // Last pass is compare mode with edges enabled: no capture allowed
    prev = cnt + 16'h0008;
    for (int i = 0; i < 5; i++) begin
      cnt = 16'($urandom());
      setCount(cnt);
      ctl = (i < 4) ? {2'(i), 2'h1, i[0], 3'h1, 8'h00} : 16'hD000;
      wr(ccr_pkg::ADDR_CONTROL, ctl);
      levelB <= 1'b1;
      ticks(6);
      levelB <= 1'b0;
      ticks(6);
      if (i > 0 && i < 4) prev = cnt;
      rd("capture", ccr_pkg::ADDR_VALUE, prev);
    end
    $display("capture test done");

    wr(ccr_pkg::ADDR_STATUS, 16'h0007);
    wr(ccr_pkg::ADDR_MASK, 16'h0004);
    levelA <= 1'b0;
    ticks(6);
    wr(ccr_pkg::ADDR_CONTROL, 16'h4100);
    levelA <= 1'b1;
    ticks(6);
    levelA <= 1'b0;
    ticks(6);
    cnt = 16'($urandom());
    setCount(cnt);
    levelA <= 1'b1;
    ticks(6);
    chk("irq lost", 16'h0001, {15'h0, irq});
    rd("lost ctl", ccr_pkg::ADDR_CONTROL, 16'h450B);
    rd("lost value", ccr_pkg::ADDR_VALUE, cnt);
    rd("lost kept", ccr_pkg::ADDR_CONTROL, 16'h450B);
    wr(ccr_pkg::ADDR_CONTROL, 16'h4101);
    rd("lost clear", ccr_pkg::ADDR_CONTROL, 16'h4509);
    rd("lost stat", ccr_pkg::ADDR_STATUS, 16'h0005);
    wr(ccr_pkg::ADDR_STATUS, 16'h0004);
    ticks(1);
    chk("irq lost off", 16'h0000, {15'h0, irq});
    wr(ccr_pkg::ADDR_CONTROL, 16'h3000);
    rd("source high", ccr_pkg::ADDR_CONTROL, 16'h3408);
    $display("overflow test done");
    ticks(2);
    results();
  end
endmodule
`default_nettype wire

/* test/ccr_far_side.sv */
`timescale 1ns/1ns
`default_nettype none
module ccr_far_side #(
  parameter logic [15:0] COUNT_INIT = 16'h1000
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        run,
  input  wire logic        load,
  input  wire logic [15:0] loadValue,
  input  wire logic        levelA,
  input  wire logic        levelB,
  output logic      [15:0] timerCountValue,
  output logic             inputSourceA,
  output logic             inputSourceB
);
  // Count may stall, as a stopped or slow timer clock would
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      timerCountValue <= COUNT_INIT;
    end else if (load) begin
      timerCountValue <= loadValue;
    end else if (run) begin
      timerCountValue <= timerCountValue + 16'h0001;
    end
  end
  // Pins move mid-cycle so the synchroniser sees a truly async edge
  initial begin
    inputSourceA = 1'b0;
    inputSourceB = 1'b0;
  end
  always @(levelA) inputSourceA <= #7 levelA;
  always @(levelB) inputSourceB <= #7 levelB;
endmodule
`default_nettype wire
